//--- shared/pmw_map.svh
// Register offsets, field positions, reset values and timing figures
`ifndef PMW_MAP_SVH
`define PMW_MAP_SVH

// ==========================================================
// Register offsets
`define PMW_ADDR_MODE 8'h00
`define PMW_ADDR_WAKE 8'h01
`define PMW_ADDR_STAT 8'h02

// ==========================================================
// Mode control fields
`define PMW_MODE_STOP_BIT 1
`define PMW_MODE_SLOW_BIT 2
`define PMW_MODE_SEL_LO 3
`define PMW_MODE_SEL_HI 4

// ==========================================================
// Wake config and status fields
`define PMW_WAKE_TMR_BIT 0
`define PMW_STAT_MODE_LO 0
`define PMW_STAT_MODE_HI 1
`define PMW_STAT_FAST_BIT 2
`define PMW_STAT_SETTLE_BIT 3
`define PMW_STAT_PIN_BIT 4
`define PMW_STAT_USB_BIT 5
`define PMW_STAT_TMR_BIT 6

// ==========================================================
// Reset values
`define PMW_MODE_RST 8'h00
`define PMW_WAKE_RST 8'h00

// ==========================================================
// Timing figures
`define PMW_SYS_HZ 64'd200000000
`define PMW_HCLK_HZ 64'd6000000
`define PMW_LCLK_HZ 64'd32000
`define PMW_WAKE_HCLKS 64'd2048
`define PMW_OSC_START_NS 64'd1000
`define PMW_SLOW_CPU_DIV 4

`endif

//--- shared/pmw_pkg.sv
// Types shared by the power mode and wake-up controller
package pmw_pkg;

  // ==========================================================
  // Controller states
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_GREEN = 3'b001,
    ST_SLEEP = 3'b010,
    ST_WAKE = 3'b011
  } pmw_state_e;

  // ==========================================================
  // Mode select encodings
  typedef enum logic [1:0] {
    SEL_NORMAL = 2'b00,
    SEL_SLEEP = 2'b01,
    SEL_GREEN = 2'b10,
    SEL_RSVD = 2'b11
  } pmw_sel_e;

  // ==========================================================
  // Operating mode shown to software
  typedef enum logic [1:0] {
    OPM_NORMAL = 2'b00,
    OPM_SLOW = 2'b01,
    OPM_GREEN = 2'b10,
    OPM_SLEEP = 2'b11
  } pmw_opmode_e;

endpackage : pmw_pkg

//--- shared/pmw_wake_if.sv
// Wake trigger pulses from the pin detector to the mode controller
`timescale 1ns/1ps
`default_nettype none

interface pmw_wake_if;
  logic pin_change;
  logic usb_toggle;

  modport det (output pin_change, output usb_toggle);
  modport ctrl (input pin_change, input usb_toggle);
endinterface : pmw_wake_if

`default_nettype wire

//--- hw/pmw_wake_det.sv
// Pin synchronisers and level change detection for wake triggers
`timescale 1ns/1ps
`default_nettype none

module pmw_wake_det
  import pmw_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Raw pins
  input wire logic [23:0] port_pins,
  input wire logic [1:0] usb_bus,
  // Trigger pulses
  pmw_wake_if.det wake
);

  logic [25:0] meta_q;
  logic [25:0] sync_q;
  logic [25:0] prev_q;
  logic [1:0] prime_q;
  logic primed;
  logic pin_change_q;
  logic usb_toggle_q;

  // ==========================================================
  // Two-stage synchroniser
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_q <= 26'h0;
      sync_q <= 26'h0;
    end else begin
      meta_q <= {usb_bus, port_pins};
      sync_q <= meta_q;
    end
  end

  // ==========================================================
  // Change detection; held off until the previous sample holds a real
  // pin level, so the zeroed reset state cannot fake an edge
  assign primed = (prime_q == 2'h3);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prev_q <= 26'h0;
      prime_q <= 2'h0;
      pin_change_q <= 1'b0;
      usb_toggle_q <= 1'b0;
    end else begin
      prev_q <= sync_q;
      if (!primed) begin
        prime_q <= prime_q + 2'h1;
      end
      pin_change_q <= primed && (|(sync_q[23:0] ^ prev_q[23:0]));
      usb_toggle_q <= primed && (|(sync_q[25:24] ^ prev_q[25:24]));
    end
  end

  assign wake.pin_change = pin_change_q;
  assign wake.usb_toggle = usb_toggle_q;

endmodule : pmw_wake_det

`default_nettype wire

//--- hw/pmw_ctrl.sv
// Operating mode and wake-up controller top
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pmw_map.svh"

// Behaviour
// - Four modes: normal, slow, green, sleep
// - Mode select 01 enters sleep
// - Mode select 10 enters green
// - Slow select switches system to low clock
// - Oscillator stop halts fast clock in slow
// - Clearing slow select returns to normal at once
// - Sleep and green suspend instruction execution
// - Wake on port changes, timer, USB toggle
// - Sleep wakes to normal, never on timer
// - Green returns to mode active before entry
// - Timer wake off: only pins and USB toggle wake green
// - Timer wake on: pins and timer wake green; this code still wakes green on USB toggle too
// - Sleep stops the fast oscillator
// - Sleep wake waits 2048 clocks plus start-up
// - Green wake resumes with no delay
// - Select codes: 00 normal, 01 sleep, 10 green
// - Slow select 0 high clock, 1 low clock
// - Slow instruction rate is low clock over four
module pmw_ctrl
  import pmw_pkg::*;
#(
  parameter int WAKE_CYC = int'((`PMW_WAKE_HCLKS * `PMW_SYS_HZ
    + `PMW_HCLK_HZ - 64'd1) / `PMW_HCLK_HZ),
  parameter int LCLK_DIV = int'(`PMW_SYS_HZ / `PMW_LCLK_HZ)
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Wake-up pins
  input wire logic [7:0] port0_pins,
  input wire logic [7:0] port1_pins,
  input wire logic [7:0] port2_pins,
  input wire logic [1:0] usb_bus,
  // Peripheral status and enables
  input wire logic tmr_a_overflow,
  input wire logic tmr_a_enable,
  input wire logic tmr_b_enable,
  input wire logic usb_engine_enable,
  // Clock and execution control
  output logic cpu_step,
  output logic cpu_run,
  output logic internal_fast_osc_en,
  output logic internal_slow_osc_en,
  output logic sys_clk_slow,
  output logic [1:0] op_mode,
  output logic wake_settling,
  // Peripheral activity
  output logic tmr_a_active,
  output logic tmr_b_active,
  output logic usb_active
);

  // ==========================================================
  // Derived counts
  localparam int START_CYC = int'((`PMW_OSC_START_NS * `PMW_SYS_HZ
    + 64'd999999999) / 64'd1000000000);
  localparam int HCLK_DIV = int'(`PMW_SYS_HZ / `PMW_HCLK_HZ);
  localparam logic [19:0] SETTLE_LOAD = 20'(WAKE_CYC + START_CYC - 1);
  localparam logic [5:0] HDIV_LAST = 6'(HCLK_DIV - 1);
  localparam logic [12:0] LDIV_LAST = 13'(LCLK_DIV - 1);
  localparam logic [1:0] SLOW_LAST = 2'(`PMW_SLOW_CPU_DIV - 1);
  localparam logic [7:0] MODE_RST = `PMW_MODE_RST;
  localparam logic [7:0] WAKE_RST = `PMW_WAKE_RST;

  // Where a write of the mode select leads from the running state
  function automatic pmw_state_e sel_target(input logic [1:0] sel);
    unique case (sel)
      SEL_SLEEP: sel_target = ST_SLEEP;
      SEL_GREEN: sel_target = ST_GREEN;
      SEL_NORMAL: sel_target = ST_RUN;
      SEL_RSVD: sel_target = ST_RUN;
    endcase
  endfunction : sel_target

  pmw_wake_if wake_bus ();

  pmw_wake_det u_wake_det (
    .sys_clk (sys_clk),
    .reset (reset),
    .port_pins ({port2_pins, port1_pins, port0_pins}),
    .usb_bus (usb_bus),
    .wake (wake_bus.det)
  );

  pmw_state_e state_q;
  logic [1:0] cpu_mode_sel_q;
  logic slow_clock_sel_q;
  logic high_osc_stop_q;
  logic tmr_wake_en_q;
  logic [19:0] settle_cnt_q;
  logic [5:0] hdiv_q;
  logic [12:0] ldiv_q;
  logic [1:0] slow_div_q;
  logic [2:0] cause_q;
  logic [7:0] rdata_q;
  logic cpu_step_q;
  logic cpu_run_q;
  logic fast_osc_q;
  logic slow_osc_q;
  logic sys_slow_q;
  logic [1:0] op_mode_q;
  logic settling_q;
  logic tmr_a_act_q;
  logic tmr_b_act_q;
  logic usb_act_q;
  logic mode_wr;
  logic ext_trig;
  logic tmr_trig;
  logic green_wake;
  logic sleep_wake;
  logic hi_tick;
  logic lo_tick;
  logic fast_osc_d;
  logic [1:0] op_mode_d;

  // Mode register writes only land while instructions execute
  assign mode_wr = reg_wr && (reg_addr == `PMW_ADDR_MODE)
    && (state_q == ST_RUN);
  assign ext_trig = wake_bus.ctrl.pin_change || wake_bus.ctrl.usb_toggle;
  assign tmr_trig = tmr_wake_en_q && tmr_a_enable && tmr_a_overflow;
  assign green_wake = ext_trig || tmr_trig;
  assign sleep_wake = ext_trig;
  assign hi_tick = (hdiv_q == HDIV_LAST);
  assign lo_tick = (ldiv_q == LDIV_LAST);

  // ==========================================================
  // Mode state machine
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= ST_RUN;
    end else begin
      unique case (state_q)
        ST_RUN: begin
          if (mode_wr) begin
            state_q <= sel_target(
              reg_wdata[`PMW_MODE_SEL_HI:`PMW_MODE_SEL_LO]);
          end
        end
        ST_GREEN: begin
          if (green_wake) begin
            state_q <= ST_RUN;
          end
        end
        ST_SLEEP: begin
          if (sleep_wake) begin
            state_q <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (settle_cnt_q == 20'h0) begin
            state_q <= ST_RUN;
          end
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // ==========================================================
  // Oscillator settling count after sleep
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      settle_cnt_q <= 20'h0;
    end else if (state_q == ST_SLEEP && sleep_wake) begin
      settle_cnt_q <= SETTLE_LOAD;
    end else if (state_q == ST_WAKE && settle_cnt_q != 20'h0) begin
      settle_cnt_q <= settle_cnt_q - 20'h1;
    end
  end

  // ==========================================================
  // Mode control register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cpu_mode_sel_q <= MODE_RST[`PMW_MODE_SEL_HI:`PMW_MODE_SEL_LO];
      slow_clock_sel_q <= MODE_RST[`PMW_MODE_SLOW_BIT];
      high_osc_stop_q <= MODE_RST[`PMW_MODE_STOP_BIT];
    end else if (mode_wr) begin
      // Reserved code is not kept so it cannot stand as a mode
      if (reg_wdata[`PMW_MODE_SEL_HI:`PMW_MODE_SEL_LO] == SEL_RSVD) begin
        cpu_mode_sel_q <= SEL_NORMAL;
      end else begin
        cpu_mode_sel_q <= reg_wdata[`PMW_MODE_SEL_HI:`PMW_MODE_SEL_LO];
      end
      slow_clock_sel_q <= reg_wdata[`PMW_MODE_SLOW_BIT];
      high_osc_stop_q <= reg_wdata[`PMW_MODE_STOP_BIT];
    end else if (state_q == ST_SLEEP && sleep_wake) begin
      // Sleep always comes back on the fast clock, oscillator restarted
      cpu_mode_sel_q <= SEL_NORMAL;
      slow_clock_sel_q <= 1'b0;
      high_osc_stop_q <= 1'b0;
    end else if (state_q == ST_GREEN && green_wake) begin
      cpu_mode_sel_q <= SEL_NORMAL;
    end
  end

  // ==========================================================
  // Wake config and wake cause
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tmr_wake_en_q <= WAKE_RST[`PMW_WAKE_TMR_BIT];
    end else if (reg_wr && reg_addr == `PMW_ADDR_WAKE) begin
      tmr_wake_en_q <= reg_wdata[`PMW_WAKE_TMR_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cause_q <= 3'h0;
    end else if (state_q == ST_GREEN && green_wake) begin
      cause_q <= {tmr_trig, wake_bus.ctrl.usb_toggle,
        wake_bus.ctrl.pin_change};
    end else if (state_q == ST_SLEEP && sleep_wake) begin
      cause_q <= {1'b0, wake_bus.ctrl.usb_toggle,
        wake_bus.ctrl.pin_change};
    end
  end

  // ==========================================================
  // Rate dividers: fast clock tick and slow clock quarter
  always_ff @(posedge sys_clk) begin
    if (reset || hi_tick) begin
      hdiv_q <= 6'h0;
    end else begin
      hdiv_q <= hdiv_q + 6'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || lo_tick) begin
      ldiv_q <= 13'h0;
    end else begin
      ldiv_q <= ldiv_q + 13'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      slow_div_q <= 2'h0;
    end else if (lo_tick) begin
      slow_div_q <= slow_div_q + 2'h1;
    end
  end

  // ==========================================================
  // Clock, execution and activity outputs
  // Stop is only honoured on the slow clock; the fast clock cannot be
  // pulled from under a running normal-mode core.
  always_comb begin
    fast_osc_d = !(state_q == ST_SLEEP)
      && !(high_osc_stop_q && slow_clock_sel_q);
    unique case (state_q)
      ST_GREEN: op_mode_d = OPM_GREEN;
      ST_SLEEP: op_mode_d = OPM_SLEEP;
      ST_WAKE: op_mode_d = OPM_SLEEP;
      default: op_mode_d = slow_clock_sel_q ? OPM_SLOW : OPM_NORMAL;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cpu_step_q <= 1'b0;
      cpu_run_q <= 1'b0;
    end else begin
      cpu_run_q <= (state_q == ST_RUN);
      cpu_step_q <= (state_q == ST_RUN) && (slow_clock_sel_q
        ? (lo_tick && slow_div_q == SLOW_LAST) : hi_tick);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fast_osc_q <= 1'b1;
      slow_osc_q <= 1'b1;
      sys_slow_q <= 1'b0;
      op_mode_q <= OPM_NORMAL;
      settling_q <= 1'b0;
    end else begin
      fast_osc_q <= fast_osc_d;
      slow_osc_q <= (state_q != ST_SLEEP);
      sys_slow_q <= slow_clock_sel_q;
      op_mode_q <= op_mode_d;
      settling_q <= (state_q == ST_WAKE);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tmr_a_act_q <= 1'b0;
      tmr_b_act_q <= 1'b0;
      usb_act_q <= 1'b0;
    end else begin
      tmr_a_act_q <= tmr_a_enable && (state_q != ST_SLEEP)
        && (state_q != ST_WAKE);
      tmr_b_act_q <= tmr_b_enable && (state_q == ST_RUN);
      usb_act_q <= usb_engine_enable && (state_q == ST_RUN)
        && !slow_clock_sel_q;
    end
  end

  // ==========================================================
  // Register read port, data one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_q <= 8'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `PMW_ADDR_MODE: rdata_q <= {3'h0, cpu_mode_sel_q,
          slow_clock_sel_q, high_osc_stop_q, 1'b0};
        `PMW_ADDR_WAKE: rdata_q <= {7'h0, tmr_wake_en_q};
        `PMW_ADDR_STAT: rdata_q <= {1'b0, cause_q, settling_q,
          fast_osc_q, op_mode_d};
        default: rdata_q <= 8'h0;
      endcase
    end else begin
      rdata_q <= 8'h0;
    end
  end

  assign reg_rdata = rdata_q;
  assign cpu_step = cpu_step_q;
  assign cpu_run = cpu_run_q;
  assign internal_fast_osc_en = fast_osc_q;
  assign internal_slow_osc_en = slow_osc_q;
  assign sys_clk_slow = sys_slow_q;
  assign op_mode = op_mode_q;
  assign wake_settling = settling_q;
  assign tmr_a_active = tmr_a_act_q;
  assign tmr_b_active = tmr_b_act_q;
  assign usb_active = usb_act_q;

  // ==========================================================
  // Checks
  chk_sleep_entry: assert property (@(posedge sys_clk) disable iff (reset)
    mode_wr && reg_wdata[4:3] == 2'b01
    |=> state_q == ST_SLEEP ##1 !cpu_run && !internal_fast_osc_en)
    else $error("sleep not entered on select 01");

  chk_green_entry: assert property (@(posedge sys_clk) disable iff (reset)
    mode_wr && reg_wdata[4:3] == 2'b10
    |=> state_q == ST_GREEN ##1 op_mode == OPM_GREEN)
    else $error("green not entered on select 10");

  chk_rsvd_stays: assert property (@(posedge sys_clk) disable iff (reset)
    mode_wr && reg_wdata[4:3] == 2'b11
    |=> state_q == ST_RUN ##1 cpu_run)
    else $error("reserved select left the running state");

  chk_slow_clock: assert property (@(posedge sys_clk) disable iff (reset)
    mode_wr |=> ##1 sys_clk_slow == $past(reg_wdata[2], 2))
    else $error("system clock select does not follow write");

  chk_osc_stop: assert property (@(posedge sys_clk) disable iff (reset)
    state_q == ST_RUN && slow_clock_sel_q && high_osc_stop_q
    |=> !internal_fast_osc_en && internal_slow_osc_en)
    else $error("fast oscillator still on after stop");

  chk_sleep_osc: assert property (@(posedge sys_clk) disable iff (reset)
    state_q == ST_SLEEP |=> !internal_fast_osc_en && !cpu_step)
    else $error("fast oscillator runs in sleep");

  chk_halt_exec: assert property (@(posedge sys_clk) disable iff (reset)
    cpu_step |-> $past(state_q) == ST_RUN)
    else $error("instruction step outside running state");

  chk_sleep_tmr: assert property (@(posedge sys_clk) disable iff (reset)
    state_q == ST_SLEEP && !ext_trig |=> state_q == ST_SLEEP)
    else $error("sleep left without external trigger");

  chk_green_tmr: assert property (@(posedge sys_clk) disable iff (reset)
    state_q == ST_GREEN && tmr_trig
    |=> state_q == ST_RUN && $stable(slow_clock_sel_q))
    else $error("timer overflow did not resume from green");

  chk_green_hold: assert property (@(posedge sys_clk) disable iff (reset)
    state_q == ST_GREEN && !ext_trig && !tmr_wake_en_q
    |=> state_q == ST_GREEN)
    else $error("green left with timer wake disabled");

  chk_green_fast: assert property (@(posedge sys_clk) disable iff (reset)
    state_q == ST_GREEN && ext_trig |=> state_q == ST_RUN ##1 cpu_run)
    else $error("green wake was delayed");

  chk_wake_len: assert property (@(posedge sys_clk) disable iff (reset)
    $past(state_q) == ST_WAKE && state_q == ST_RUN
    |-> $past(settle_cnt_q) == 20'h0 && !slow_clock_sel_q)
    else $error("sleep wake ended before settling count");

  chk_slow_rate: assert property (@(posedge sys_clk) disable iff (reset)
    cpu_step && $past(slow_clock_sel_q)
    |-> $past(lo_tick) && $past(slow_div_q) == 2'h3)
    else $error("slow step not at quarter of low clock");

endmodule : pmw_ctrl

`default_nettype wire

//--- verif/pmw_wake_src.sv
// Far-side model of wake pins, USB lines and timer A overflow
`timescale 1ns/1ps
`default_nettype none

module pmw_wake_src #(
  // Interval that software programs into timer A before green
  parameter int TMR_PERIOD = 40
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Timer enable
  input wire logic tmr_a_enable,
  // Wake sources
  output logic [7:0] port0_pins,
  output logic [7:0] port1_pins,
  output logic [7:0] port2_pins,
  output logic [1:0] usb_bus,
  output var logic tmr_a_overflow
);
  int tmr_cnt_q;
  logic [23:0] pins_q;

  // Pins are levels held outside, so they keep their last value
  assign port0_pins = pins_q[7:0];
  assign port1_pins = pins_q[15:8];
  assign port2_pins = pins_q[23:16];

  initial begin
    pins_q = 24'h000000;
    usb_bus = 2'b01;
    tmr_a_overflow = 1'b0;
  end

  // ==========================================================
  // Level change on one of the 24 port pins
  task automatic toggle_pin(input int idx);
    @(posedge sys_clk);
    pins_q[idx] <= ~pins_q[idx];
  endtask : toggle_pin

  // Bus activity flips both lines
  task automatic toggle_usb();
    @(posedge sys_clk);
    usb_bus <= ~usb_bus;
  endtask : toggle_usb

  // ==========================================================
  // Timer A runs freely while enabled, one-cycle overflow pulse
  always @(posedge sys_clk) begin
    if (reset || !tmr_a_enable) begin
      tmr_cnt_q <= 0;
      tmr_a_overflow <= 1'b0;
    end else begin
      tmr_cnt_q <= (tmr_cnt_q == TMR_PERIOD - 1) ? 0 : tmr_cnt_q + 1;
      tmr_a_overflow <= (tmr_cnt_q == TMR_PERIOD - 1);
    end
  end
endmodule : pmw_wake_src

`default_nettype wire

//--- verif/pmw_ctrl_bench.sv
// Self-checking bench for the power mode and wake-up controller
`timescale 1ns/1ps
`default_nettype none
`include "pmw_map.svh"

module pmw_ctrl_bench
  import pmw_pkg::*;
;
  localparam int WAKE_CYC = 20;
  localparam int LCLK_DIV = 8;
  // Settle count plus the fixed 200-cycle start-up
  localparam int SETTLE = WAKE_CYC + 200;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tmr_a_enable = 1'b1;
  logic tmr_b_enable = 1'b1;
  logic usb_engine_enable = 1'b1;
  logic [7:0] reg_rdata, p0, p1, p2, rd_q;
  logic [1:0] usb_bus, op_mode;
  logic tmr_a_overflow, cpu_step, cpu_run, fast_en, slow_en;
  logic sys_clk_slow, wake_settling, tmr_a_act, tmr_b_act, usb_act;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int n;

  always #2.5 sys_clk = ~sys_clk;

  pmw_wake_src src (.sys_clk(sys_clk), .reset(reset),
    .tmr_a_enable(tmr_a_enable), .port0_pins(p0), .port1_pins(p1),
    .port2_pins(p2), .usb_bus(usb_bus), .tmr_a_overflow(tmr_a_overflow));

  pmw_ctrl #(.WAKE_CYC(WAKE_CYC), .LCLK_DIV(LCLK_DIV)) dut (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .port0_pins(p0), .port1_pins(p1),
    .port2_pins(p2), .usb_bus(usb_bus), .tmr_a_overflow(tmr_a_overflow),
    .tmr_a_enable(tmr_a_enable), .tmr_b_enable(tmr_b_enable),
    .usb_engine_enable(usb_engine_enable), .cpu_step(cpu_step),
    .cpu_run(cpu_run), .internal_fast_osc_en(fast_en),
    .internal_slow_osc_en(slow_en), .sys_clk_slow(sys_clk_slow),
    .op_mode(op_mode), .wake_settling(wake_settling),
    .tmr_a_active(tmr_a_act), .tmr_b_active(tmr_b_act),
    .usb_active(usb_act));

  // ==========================================================
  // Shared tasks
  task automatic results();
    $display("Checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [7:0] got,
    input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the read edge
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rd_q = reg_rdata;
  endtask : rd

  task automatic wait_run(input int lim);
    n = 0;
    while (cpu_run !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : wait_run

  task automatic step_gap();
    int k;
    k = 0;
    while (cpu_step !== 1'b1 && k < 200) begin
      cyc(1);
      k++;
    end
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (cpu_step !== 1'b1 && n < 200);
  endtask : step_gap

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd(`PMW_ADDR_MODE);
    chk("mode reg", rd_q, `PMW_MODE_RST);
    rd(`PMW_ADDR_WAKE);
    chk("wake reg", rd_q, `PMW_WAKE_RST);
    rd(8'h7f);
    chk("unmapped", rd_q, 8'h00);
    chk("op mode", op_mode, OPM_NORMAL);
    chk("usb in normal", usb_act, 1'b1);
    chk("tmr b normal", tmr_b_act, 1'b1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_slow();
    wr(`PMW_ADDR_MODE, 8'h04);
    cyc(3);
    chk("slow clk", sys_clk_slow, 1'b1);
    chk("slow mode", op_mode, OPM_SLOW);
    chk("usb in slow", usb_act, 1'b0);
    chk("tmr a slow", tmr_a_act, 1'b1);
    step_gap();
    chk("slow step gap", n[7:0], 8'(LCLK_DIV * 4));
    wr(`PMW_ADDR_MODE, 8'h06);
    cyc(3);
    chk("osc stopped", fast_en, 1'b0);
    chk("slow osc", slow_en, 1'b1);
    wr(`PMW_ADDR_MODE, 8'h04);
    wr(`PMW_ADDR_MODE, 8'h00);
    cyc(3);
    chk("normal again", op_mode, OPM_NORMAL);
    chk("fast clk", sys_clk_slow, 1'b0);
    chk("fast osc", fast_en, 1'b1);
    step_gap();
    chk("fast step gap", n[7:0], 8'd33);
    $display("test slow done");
  endtask : t_slow

  task automatic t_reserved();
    wr(`PMW_ADDR_MODE, 8'h18);
    cyc(3);
    chk("rsvd run", cpu_run, 1'b1);
    chk("rsvd mode", op_mode, OPM_NORMAL);
    rd(`PMW_ADDR_MODE);
    chk("rsvd sel", rd_q[4:3], 8'h00);
    $display("test reserved done");
  endtask : t_reserved

  // One pin on each port, slow entry on port 1; timer wake disabled
  task automatic t_green_pins();
    int k;
    for (int p = 0; p < 3; p++) begin
      if (p == 1) begin
        wr(`PMW_ADDR_MODE, 8'h04);
      end
      wr(`PMW_ADDR_MODE, (p == 1) ? 8'h14 : 8'h10);
      cyc(3);
      chk("green", op_mode, OPM_GREEN);
      chk("halted", cpu_run, 1'b0);
      chk("tmr b green", tmr_b_act, 1'b0);
      chk("tmr a green", tmr_a_act, 1'b1);
      k = 0;
      repeat (60) begin
        cyc(1);
        k += (cpu_step === 1'b1);
      end
      chk("steps in green", k[7:0], 8'h00);
      chk("timer ignored", op_mode, OPM_GREEN);
      src.toggle_pin(p * 8 + 2 + p);
      wait_run(12);
      chk("green wake fast", n <= 6, 1'b1);
      chk("back to", op_mode, (p == 1) ? OPM_SLOW : OPM_NORMAL);
      rd(`PMW_ADDR_STAT);
      chk("pin cause", rd_q[6:4], 8'h01);
      wr(`PMW_ADDR_MODE, 8'h00);
    end
    $display("test green pins done");
  endtask : t_green_pins

  task automatic t_green_tmr();
    wr(`PMW_ADDR_WAKE, 8'h01);
    wr(`PMW_ADDR_MODE, 8'h10);
    cyc(3);
    wait_run(60);
    chk("tmr wake", cpu_run, 1'b1);
    rd(`PMW_ADDR_STAT);
    chk("tmr cause", rd_q[6:4], 8'h04);
    wr(`PMW_ADDR_WAKE, 8'h00);
    $display("test green timer done");
  endtask : t_green_tmr

  task automatic t_sleep();
    wr(`PMW_ADDR_MODE, 8'h04);
    wr(`PMW_ADDR_MODE, 8'h0c);
    cyc(3);
    chk("sleep", op_mode, OPM_SLEEP);
    chk("fast osc off", fast_en, 1'b0);
    chk("slow osc off", slow_en, 1'b0);
    chk("tmr a sleep", tmr_a_act, 1'b0);
    cyc(100);
    chk("no tmr wake", op_mode, OPM_SLEEP);
    src.toggle_usb();
    cyc(6);
    chk("settling", wake_settling, 1'b1);
    wait_run(SETTLE + 20);
    chk("settle len", n + 6 >= SETTLE && n + 6 <= SETTLE + 8, 1'b1);
    chk("wake normal", op_mode, OPM_NORMAL);
    rd(`PMW_ADDR_MODE);
    chk("mode cleared", rd_q, 8'h00);
    rd(`PMW_ADDR_STAT);
    chk("usb cause", rd_q[6:4], 8'h02);
    $display("test sleep done");
  endtask : t_sleep

  // ==========================================================
  // Hang guard, well above the expected run length
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      results();
    end
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    cyc(4);
    t_reset();
    t_slow();
    t_reserved();
    t_green_pins();
    t_green_tmr();
    t_sleep();
    results();
  end
endmodule : pmw_ctrl_bench

`default_nettype wire
